/* hw/ebp_pkg.sv */
// Package for the bootstrap programmer: constants, states and carrier structs
package ebp_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] FIRST_ADDR = 12'h080;
   localparam logic [ADDR_W-1:0] IMAGE_BYTES = 12'h83a;
   localparam logic [ADDR_W-1:0] SELF_LAST_ADDR = 12'h8b9;
   localparam logic [ADDR_W-1:0] CTR_LAST_ADDR = 12'h7ff;
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_MHZ = 200;
   // About 95 ms a byte, so 2106 bytes take roughly 200 s
   localparam int STEP_US = 95000;
   localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
   localparam int LAMP_GAP_MS = 2000;
   localparam int LAMP_GAP_CYCLES = LAMP_GAP_MS * 1000 * CLK_MHZ;
   localparam int SRC_SETTLE_NS = 20;
   localparam int SRC_SETTLE_CYCLES = (SRC_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SEL_BIT = 11;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CLR_HI, ST_CLR_LO, ST_FETCH, ST_WAIT, ST_STEP, ST_NEXT, ST_DONE_PROG, ST_GAP, ST_PASS, ST_FAIL
   } ebp_state_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ebp_byte_s;

   typedef struct packed {
      logic programmed_n;
      logic in_progress_n;
      logic verified_n;
   } ebp_lamps_s;
endpackage : ebp_pkg

/* hw/ebp_fifo.sv */
// Byte FIFO between the source reader and the program-memory writer
`timescale 1ns/1ps
module ebp_fifo
   import ebp_pkg::*;
#(
   parameter int WIDTH = ADDR_W + DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_ptr;
   logic [PW:0] rd_ptr;
   logic do_wr;
   logic do_rd;

   assign in_ready = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem[rd_ptr[PW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr[PW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : ebp_fifo

/* hw/ebp_programmer.sv */
// Bootstrap sequencer: copies source memory into program memory, then verifies
`timescale 1ns/1ps
// Operation
// - Counter variant: pulse counter clear high then low before any step pulse.
// - Counter variant: pulse counter step after each byte is written.
// - Repeat read, program, advance until all program memory is written.
// - Source address equals program address; lowest 128 source bytes unused.
// - Self-addressing: drive programming-voltage control low after reset.
// - Write program memory one byte per step from matching source location.
// - Self-addressing: drive source address and two chip selects itself.
// - After transfer, restart address at zero and compare each byte.
// - Self-addressing: full transfer takes about 200 seconds.
// - Self-addressing: in-progress lamp on throughout programming.
// - Self-addressing: on pass, in-progress lamp off, verified lamp on.
// - Counter variant: programmed lamp first, verified lamp after passing.
// - Self-addressing: image spans 2106 bytes within 4K source space.
// - Counter variant: both lamps active low, verified about two seconds later.
// - Self-addressing: both lamps active low.
module ebp_programmer
   import ebp_pkg::*;
#(
   parameter bit SELF_ADDR = 1'b0,
   parameter int STEP_CNT = STEP_CYCLES,
   parameter int GAP_CNT = LAMP_GAP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [DATA_W-1:0] src_data,
   output logic [ADDR_W-1:0] src_addr,
   output logic [1:0] source_mem_selects,
   output logic counter_clear_out,
   output logic counter_step_out,
   output logic prog_voltage_ctl,
   output logic pm_wr,
   output logic [ADDR_W-1:0] pm_addr,
   output logic [DATA_W-1:0] pm_wdata,
   input wire logic [DATA_W-1:0] pm_rdata,
   output logic programmed_ind_out,
   output logic verified_ind_out_a,
   output logic in_progress_ind_out,
   output logic verified_ind_out_b,
   output logic busy
);
   localparam logic [ADDR_W-1:0] LAST = SELF_ADDR ? SELF_LAST_ADDR : CTR_LAST_ADDR;
   localparam int SETTLE = SRC_SETTLE_CYCLES < 1 ? 1 : SRC_SETTLE_CYCLES;

   ebp_state_e state;
   logic verify;
   logic mismatch;
   logic [ADDR_W-1:0] addr;
   logic [31:0] timer;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   ebp_byte_s fifo_in;
   ebp_byte_s fifo_out;
   ebp_lamps_s lamps;
   logic fetch_push;

   // Bytes below the first address exist in the source but are never taken
   assign fetch_push = (state == ST_FETCH) && timer == 32'(SETTLE) && fifo_in_ready && addr >= FIRST_ADDR;
   assign fifo_in.addr = addr;
   assign fifo_in.data = src_data;
   // Writer drains one byte per step period and the sequencer waits for it, so the FIFO never holds more than one byte
   assign fifo_out_ready = timer == 32'(STEP_CNT) || verify;

   ebp_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .flush(state == ST_DONE_PROG),
      .in_valid(fetch_push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         addr <= '0;
         timer <= '0;
         verify <= 1'b0;
      end else begin
         timer <= timer + 32'd1;
         case (state)
            ST_IDLE: begin
               timer <= '0;
               state <= SELF_ADDR ? ST_FETCH : ST_CLR_HI;
            end
            ST_CLR_HI: state <= ST_CLR_LO;
            ST_CLR_LO: begin
               timer <= '0;
               state <= ST_FETCH;
            end
            ST_FETCH: begin
               // Source settles before sampling; low bytes are skipped, not sampled
               if (addr < FIRST_ADDR) begin
                  state <= SELF_ADDR ? ST_NEXT : ST_STEP;
               end else if (timer >= 32'(SETTLE) && fifo_in_ready) begin
                  timer <= '0;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Next source address waits for the byte to be programmed or checked
               if (verify || timer >= 32'(STEP_CNT)) begin
                  state <= SELF_ADDR ? ST_NEXT : ST_STEP;
               end
            end
            ST_STEP: state <= ST_NEXT;
            ST_NEXT: begin
               timer <= '0;
               if (addr == LAST) begin
                  addr <= '0;
                  state <= verify ? ST_GAP : ST_DONE_PROG;
               end else begin
                  addr <= addr + 1'b1;
                  state <= ST_FETCH;
               end
            end
            ST_DONE_PROG: begin
               verify <= 1'b1;
               timer <= '0;
               state <= SELF_ADDR ? ST_FETCH : ST_CLR_HI;
            end
            ST_GAP: begin
               if (mismatch) begin
                  state <= ST_FAIL;
               end else if (SELF_ADDR || timer >= 32'(GAP_CNT)) begin
                  state <= ST_PASS;
               end
            end
            ST_PASS: state <= ST_PASS;
            ST_FAIL: state <= ST_FAIL;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Writer stage: one byte each step period while not verifying, in both variants
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pm_wr <= 1'b0;
         pm_addr <= '0;
         pm_wdata <= '0;
      end else begin
         pm_wr <= fifo_out_valid && fifo_out_ready && !verify;
         if (fifo_out_valid && fifo_out_ready) begin
            pm_addr <= fifo_out.addr;
            pm_wdata <= fifo_out.data;
         end
      end
   end

   // Compare is sampled while the source byte is stable at the same address
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mismatch <= 1'b0;
      end else if (verify && state == ST_WAIT && pm_rdata != src_data) begin
         mismatch <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         src_addr <= '0;
         source_mem_selects <= 2'b11;
         counter_clear_out <= 1'b0;
         counter_step_out <= 1'b0;
         prog_voltage_ctl <= 1'b1;
      end else begin
         src_addr <= SELF_ADDR ? addr : '0;
         // Two 2K parts: bit 11 picks one, selects active low
         source_mem_selects <= SELF_ADDR ? (addr[SEL_BIT] ? 2'b01 : 2'b10) : 2'b11;
         counter_clear_out <= !SELF_ADDR && state == ST_CLR_HI;
         counter_step_out <= !SELF_ADDR && state == ST_STEP;
         prog_voltage_ctl <= !(SELF_ADDR && state != ST_IDLE && !verify);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lamps <= '{programmed_n: 1'b1, in_progress_n: 1'b1, verified_n: 1'b1};
      end else begin
         lamps.programmed_n <= !(!SELF_ADDR && verify);
         lamps.in_progress_n <= !(SELF_ADDR && state != ST_IDLE && state != ST_PASS);
         lamps.verified_n <= state != ST_PASS;
      end
   end

   assign programmed_ind_out = lamps.programmed_n;
   assign verified_ind_out_a = SELF_ADDR ? 1'b1 : lamps.verified_n;
   assign in_progress_ind_out = lamps.in_progress_n;
   assign verified_ind_out_b = SELF_ADDR ? lamps.verified_n : 1'b1;
   assign busy = state != ST_PASS && state != ST_FAIL;
endmodule : ebp_programmer

/* verification/ebp_checker.sv */
// Concurrent checks on the counter-variant sequencer outputs
`timescale 1ns/1ps
module ebp_checker
   import ebp_pkg::*;
#(
   parameter int GAP_CNT = 16
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic counter_clear_out,
   input wire logic counter_step_out,
   input wire logic pm_wr,
   input wire logic [ADDR_W-1:0] pm_addr,
   input wire logic programmed_ind_out,
   input wire logic verified_ind_out_a
);
   logic seen_clr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) seen_clr <= 1'b0;
      else if (counter_clear_out) seen_clr <= 1'b1;
   end
   AST_CLR_FIRST: assert property (counter_step_out |-> seen_clr)
      else $error("step pulse before counter clear");
   AST_CLR_PULSE: assert property (counter_clear_out |=> !counter_clear_out)
      else $error("clear pulse too long");
   AST_STEP_PULSE: assert property (counter_step_out |=> !counter_step_out)
      else $error("step pulse too long");
   AST_WR_RANGE: assert property (pm_wr |-> pm_addr inside {[FIRST_ADDR:CTR_LAST_ADDR]})
      else $error("write outside program space");
   AST_WR_PULSE: assert property (pm_wr |=> !pm_wr)
      else $error("write strobe held");
   AST_PROG_FIRST: assert property ($fell(verified_ind_out_a) |-> !programmed_ind_out)
      else $error("verified lamp before programmed lamp");
   AST_LAMP_GAP: assert property ($fell(verified_ind_out_a) |-> !$past(programmed_ind_out, GAP_CNT))
      else $error("verified lamp too soon");
   AST_LAMP_HOLD: assert property (!programmed_ind_out |=> !programmed_ind_out)
      else $error("programmed lamp went dark");
   AST_VER_HOLD: assert property ($fell(verified_ind_out_a) |=> !verified_ind_out_a [*4])
      else $error("verified lamp flickered");
endmodule : ebp_checker

bind ebp_programmer ebp_checker #(.GAP_CNT(GAP_CNT)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .counter_clear_out(counter_clear_out), .counter_step_out(counter_step_out), .pm_wr(pm_wr),
   .pm_addr(pm_addr), .programmed_ind_out(programmed_ind_out), .verified_ind_out_a(verified_ind_out_a));

/* verification/ebp_src_model.sv */
// Source byte memory behind an external binary address counter
`timescale 1ns/1ps
module ebp_src_model
   import ebp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic counter_clear_out,
   input wire logic counter_step_out,
   output logic [ADDR_W-1:0] cnt,
   output logic [DATA_W-1:0] src_data
);
   logic [DATA_W-1:0] mem [0:4095];
   // Counter is unknown until the first clear pulse, as on the bench
   always @(posedge clk_sys) begin
      if (counter_clear_out) cnt <= '0;
      else if (counter_step_out) cnt <= cnt + 12'h001;
   end
   assign src_data = mem[cnt];
endmodule : ebp_src_model

/* verification/tb_top.sv */
// Testbench: two full program and verify passes, the second with a corrupted byte
`timescale 1ns/1ps
module tb_top
   import ebp_pkg::*;
;
   logic clk_sys, sys_rst, corrupt, clr, stp, pvc, pm_wr, prog_n, ver_a, inp_n, ver_b, busy;
   logic [DATA_W-1:0] src_data, pm_wdata, pm_rdata;
   logic [ADDR_W-1:0] src_addr, pm_addr, cnt;
   logic [1:0] sel;
   logic [DATA_W-1:0] pmem [0:4095];
   logic [31:0] seed;
   ebp_byte_s exp_q[$];
   int bad_count, cmp_count;
   ebp_programmer #(.SELF_ADDR(1'b0), .STEP_CNT(4), .GAP_CNT(16)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .src_data(src_data), .src_addr(src_addr), .source_mem_selects(sel), .counter_clear_out(clr),
      .counter_step_out(stp), .prog_voltage_ctl(pvc), .pm_wr(pm_wr), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
      .pm_rdata(pm_rdata), .programmed_ind_out(prog_n), .verified_ind_out_a(ver_a),
      .in_progress_ind_out(inp_n), .verified_ind_out_b(ver_b), .busy(busy));
   ebp_src_model u_src (.clk_sys(clk_sys), .counter_clear_out(clr), .counter_step_out(stp), .cnt(cnt),
      .src_data(src_data));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr
   task automatic stop_test;
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic chk(input logic got, input logic exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic chk_wr(input ebp_byte_s got);
      ebp_byte_s e;
      cmp_count++;
      e = (exp_q.size() == 0) ? '1 : exp_q.pop_front();
      if (got !== e) begin
         bad_count++;
         $display("unexpected at %0t: write %h, expected %h", $time, got, e);
      end
   endtask : chk_wr
   task automatic run(input logic bad);
      int n;
      sys_rst <= 1'b1;
      corrupt <= bad;
      exp_q.delete();
      for (int a = 0; a < 4096; a++) pmem[a] = '0;
      for (int a = FIRST_ADDR; a <= CTR_LAST_ADDR; a++) exp_q.push_back({a[ADDR_W-1:0], u_src.mem[a]});
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      n = 0;
      repeat (4) @(posedge clk_sys);
      while (busy !== 1'b0 && n < 60000) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (2) @(posedge clk_sys);
      chk(n < 60000, 1'b1, "sequence did not finish");
      chk(exp_q.size() == 0, 1'b1, "bytes left unwritten");
      chk(prog_n, 1'b0, "programmed lamp dark");
      chk(ver_a, bad, "verified lamp wrong");
      chk(pvc, 1'b1, "voltage control active in counter variant");
      chk(inp_n, 1'b1, "in-progress lamp lit in counter variant");
      chk(ver_b, 1'b1, "second verified lamp lit in counter variant");
      chk(sel == 2'b11 && src_addr == 12'h000, 1'b1, "selects or address driven in counter variant");
   endtask : run
   // Corrupt one verify byte in the second pass only
   always @(posedge clk_sys) pm_rdata <= pmem[cnt] ^ ((corrupt && cnt == 12'h5a5) ? 8'h01 : 8'h00);
   // Sampled on the falling edge, clear of the launching edge
   always @(negedge clk_sys) begin
      if (!sys_rst && pm_wr === 1'b1) begin
         pmem[pm_addr] = pm_wdata;
         chk_wr({pm_addr, pm_wdata});
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (95000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end
   initial begin
      sys_rst = 1'b1;
      corrupt = 1'b0;
      pm_rdata = '0;
      bad_count = 0;
      cmp_count = 0;
      seed = 32'h1a3661aa;
      for (int a = 0; a < 4096; a++) begin
         seed = lfsr(seed);
         u_src.mem[a] = seed[7:0];
      end
      run(1'b0);
      run(1'b1);
      stop_test();
   end
endmodule : tb_top
